// [design/power_sequencing_control.sv]
`timescale 1ns/1ps
module power_sequencing_control #(
  parameter int unsigned BTN_MIN_CYC = pwr_seq_pkg::BTN_MIN_CYC,
  parameter int unsigned BTN_TYP_CYC = pwr_seq_pkg::BTN_TYP_CYC
) (
  input  wire logic                                        i_clk,
  input  wire logic                                        i_rst,
  input  wire logic                                        i_power_button_in_n,
  input  wire logic                                        i_chip_power_enable_in,
  input  wire logic                                        i_deep_sleep_state_n,
  input  wire logic                                        i_standby_state_n,
  input  wire logic                                        i_thermal_trip_in_n,
  input  wire logic                                        i_platform_reset_n,
  input  wire logic                                        i_suspend_powerdown_ack,
  input  wire logic                                        i_voltage_control_alert_req,
  input  wire logic [pwr_seq_pkg::IRQ_W-1:0]               i_irq_mask,
  input  wire logic [pwr_seq_pkg::IRQ_W-1:0]               i_irq_clear,
  input  wire logic [pwr_seq_pkg::NUM_SW*pwr_seq_pkg::GRP_W-1:0] i_otp_switch_group,
  input  wire logic [pwr_seq_pkg::RAMP_W-1:0]              i_otp_ramp_cycles,
  input  wire logic                                        i_otp_memory_rail_select,
  input  wire logic [pwr_seq_pkg::ALT_W-1:0]               i_gpio_alt_sel,
  input  wire logic [pwr_seq_pkg::GPIO_W-1:0]              i_gpio_in,
  input  wire logic [pwr_seq_pkg::GPIO_W-1:0]              i_gpio_sw_out,
  input  wire logic [pwr_seq_pkg::GPIO_W-1:0]              i_gpio_sw_oe,
  output logic                                             o_debounced_button_out_n,
  output logic                                             o_rail_a_enable,
  output logic                                             o_rail_u_enable,
  output logic                                             o_rail_s_enable,
  output logic                                             o_core_power_good,
  output logic                                             o_memory_power_good,
  output logic                                             o_memory_power_good_oe,
  output logic                                             o_irq,
  output logic [pwr_seq_pkg::IRQ_W-1:0]                    o_irq_pending,
  output logic                                             o_voltage_control_alert_n,
  output logic                                             o_voltage_control_alert_n_oe,
  output logic [pwr_seq_pkg::NUM_SW-1:0]                   o_external_switch_enable,
  output logic [pwr_seq_pkg::NUM_SW-1:0]                   o_external_switch_enable_oe,
  output logic [pwr_seq_pkg::GPIO_W-1:0]                   o_gpio_out,
  output logic [pwr_seq_pkg::GPIO_W-1:0]                   o_gpio_oe
);
  import pwr_seq_pkg::*;

  logic [SYNC_W-1:0]       meta_q;
  logic [SYNC_W-1:0]       sync_q;
  logic [SYNC_W-1:0]       prev_q;
  logic                    deep_on;
  logic                    stby_on;
  logic                    therm;
  logic                    plt_rst;
  logic                    sleep_req;
  logic [NUM_SW*GRP_W-1:0] otp_grp_q;
  logic [RAMP_W-1:0]       otp_ramp_q;
  logic                    otp_memsel_q;
  pwr_state_t              state_q;
  pwr_state_t              state_d;
  logic [RAMP_W-1:0]       ramp_q;
  logic                    rail_a_d;
  logic                    rail_u_d;
  logic                    rail_s_d;
  logic                    core_pg_d;
  logic                    mem_pg_d;
  logic                    rail_a_q;
  logic                    rail_u_q;
  logic                    rail_s_q;
  logic                    core_pg_q;
  logic                    mem_pg_oe_q;
  logic [IRQ_W-1:0]        event_d;
  logic [IRQ_W-1:0]        pend_q;
  logic                    irq_q;
  logic                    alert_oe_q;
  logic                    od_low_q;
  logic [NUM_SW-1:0]       sw_oe_q;
  logic [GPIO_W-1:0]       gpio_out_d;
  logic [GPIO_W-1:0]       gpio_oe_d;
  logic [GPIO_W-1:0]       gpio_out_q;
  logic [GPIO_W-1:0]       gpio_oe_q;

  button_if btn ();

  button_debouncer #(
    .MIN_CYC (BTN_MIN_CYC),
    .TYP_CYC (BTN_TYP_CYC)
  ) u_debouncer (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .btn   (btn.dbn)
  );

  // Every pin input crosses two flops before any logic looks at it.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= SYNC_RST;
      sync_q <= SYNC_RST;
      prev_q <= SYNC_RST;
    end else begin
      meta_q <= {i_power_button_in_n, i_gpio_in[PIN_SLEEP], i_chip_power_enable_in,
                 i_suspend_powerdown_ack, i_platform_reset_n, i_thermal_trip_in_n,
                 i_standby_state_n, i_deep_sleep_state_n};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign btn.raw_n = sync_q[SY_BTN];
  assign deep_on   = sync_q[SY_DEEP];
  assign stby_on   = sync_q[SY_STBY];
  assign therm     = !sync_q[SY_THERM];
  assign plt_rst   = !sync_q[SY_PLT];
  assign sleep_req = i_gpio_alt_sel[ALT_SLEEP] && sync_q[SY_PIN8];

  // Factory settings are caught while reset is held and kept from then on.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      otp_grp_q    <= i_otp_switch_group;
      otp_ramp_q   <= i_otp_ramp_cycles;
      otp_memsel_q <= i_otp_memory_rail_select;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF: begin
        if (btn.pressed || sync_q[SY_CHIPEN]) begin
          state_d = ST_A_RAMP;
        end
      end
      ST_A_RAMP: begin
        if (ramp_q == '0) begin
          state_d = ST_A_ON;
        end
      end
      ST_A_ON: begin
        if (deep_on) begin
          state_d = ST_U_RAMP;
        end
      end
      ST_U_RAMP, ST_U_ON: begin
        if (!deep_on) begin
          state_d = ST_A_ON;
        end else if (state_q == ST_U_RAMP && ramp_q == '0) begin
          state_d = ST_U_ON;
        end else if (state_q == ST_U_ON && stby_on && !sleep_req) begin
          state_d = ST_S_RAMP;
        end
      end
      ST_S_RAMP, ST_S_ON: begin
        if (!deep_on) begin
          state_d = ST_A_ON;
        end else if (!stby_on || sleep_req) begin
          state_d = ST_U_ON;
        end else if (state_q == ST_S_RAMP && ramp_q == '0) begin
          state_d = ST_S_ON;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    // A platform reset restarts the sleep-state sequence but keeps A rails up.
    if (plt_rst && state_d != ST_OFF && state_d != ST_A_RAMP) begin
      state_d = ST_A_ON;
    end
    if (therm) begin
      state_d = ST_OFF;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Each step waits the factory soft-start length from its entry.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ramp_q <= '0;
    end else if (state_d != state_q) begin
      ramp_q <= otp_ramp_q;
    end else if (ramp_q != '0) begin
      ramp_q <= ramp_q - RAMP_W'(1);
    end
  end

  assign rail_a_d  = state_d != ST_OFF;
  assign rail_u_d  = state_d inside {ST_U_RAMP, ST_U_ON, ST_S_RAMP, ST_S_ON};
  assign rail_s_d  = state_d inside {ST_S_RAMP, ST_S_ON};
  assign core_pg_d = state_d == ST_S_ON;
  assign mem_pg_d  = state_d inside {ST_U_ON, ST_S_RAMP, ST_S_ON};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rail_a_q  <= 1'b0;
      rail_u_q  <= 1'b0;
      rail_s_q  <= 1'b0;
      core_pg_q <= 1'b0;
      mem_pg_oe_q <= 1'b1;
    end else begin
      rail_a_q  <= rail_a_d;
      rail_u_q  <= rail_u_d;
      rail_s_q  <= rail_s_d;
      core_pg_q <= core_pg_d;
      mem_pg_oe_q <= !mem_pg_d;
    end
  end

  // A switch is released to turn its load on and pulled low otherwise.
  for (genvar i = 0; i < NUM_SW; i++) begin : g_sw
    rail_grp_t grp;
    logic      on;
    assign grp = rail_grp_t'(otp_grp_q[i*GRP_W +: GRP_W]);
    assign on  = (grp == GRP_A && rail_a_d) || (grp == GRP_U && rail_u_d) ||
                 (grp == GRP_S && rail_s_d);
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        sw_oe_q[i] <= 1'b1;
      end else begin
        sw_oe_q[i] <= !on;
      end
    end
  end

  assign event_d[IRQ_THERM] = therm && sync_q[SY_THERM] != prev_q[SY_THERM];
  assign event_d[IRQ_PRESS] = btn.pressed;
  assign event_d[IRQ_ACK]   = sync_q[SY_ACK] && !prev_q[SY_ACK];
  assign event_d[IRQ_PGOOD] = core_pg_d && !core_pg_q;

  // A new event beats a clear in the same cycle.
  always_ff @(posedge i_clk) begin
    if (i_rst || plt_rst) begin
      pend_q <= '0;
      irq_q  <= 1'b0;
    end else begin
      pend_q <= (pend_q & ~i_irq_clear) | event_d;
      irq_q  <= |(pend_q & ~i_irq_mask);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      alert_oe_q <= 1'b0;
      od_low_q   <= 1'b0;
    end else begin
      alert_oe_q <= i_voltage_control_alert_req;
      od_low_q   <= 1'b0;
    end
  end

  always_comb begin
    gpio_out_d = i_gpio_sw_out;
    gpio_oe_d  = i_gpio_sw_oe;
    if (i_gpio_alt_sel[ALT_SLEEP]) begin
      gpio_oe_d[PIN_SLEEP] = 1'b0;
    end
    if (i_gpio_alt_sel[ALT_MEMSEL]) begin
      gpio_out_d[PIN_MEMSEL] = otp_memsel_q;
      gpio_oe_d[PIN_MEMSEL]  = 1'b1;
    end
    if (i_gpio_alt_sel[ALT_PANEL]) begin
      gpio_out_d[PIN_PANEL] = core_pg_d;
      gpio_oe_d[PIN_PANEL]  = 1'b1;
    end
    if (i_gpio_alt_sel[ALT_BLIGHT]) begin
      gpio_out_d[PIN_BLIGHT] = core_pg_d;
      gpio_oe_d[PIN_BLIGHT]  = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      gpio_out_q <= '0;
      gpio_oe_q  <= '0;
    end else begin
      gpio_out_q <= gpio_out_d;
      gpio_oe_q  <= gpio_oe_d;
    end
  end

  assign o_debounced_button_out_n     = btn.level_n;
  assign o_rail_a_enable              = rail_a_q;
  assign o_rail_u_enable              = rail_u_q;
  assign o_rail_s_enable              = rail_s_q;
  assign o_core_power_good            = core_pg_q;
  assign o_memory_power_good          = od_low_q;
  assign o_memory_power_good_oe       = mem_pg_oe_q;
  assign o_irq                        = irq_q;
  assign o_irq_pending                = pend_q;
  assign o_voltage_control_alert_n    = od_low_q;
  assign o_voltage_control_alert_n_oe = alert_oe_q;
  assign o_external_switch_enable     = {NUM_SW{od_low_q}};
  assign o_external_switch_enable_oe  = sw_oe_q;
  assign o_gpio_out                   = gpio_out_q;
  assign o_gpio_oe                    = gpio_oe_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_start_cause;
    $rose(rail_a_q) |-> $past(btn.pressed) || $past(sync_q[SY_CHIPEN]);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("A rails rose without cause");

  property p_deep_off;
    !deep_on && !therm |=> !rail_u_q && !core_pg_q;
  endproperty
  a_deep_off: assert property (p_deep_off) else $error("U rails stayed on");

  property p_stby_off;
    !stby_on |=> !rail_s_q && !o_core_power_good;
  endproperty
  a_stby_off: assert property (p_stby_off) else $error("S rails stayed on");

  property p_therm_off;
    therm |=> state_q == ST_OFF ##0 !rail_a_q && &sw_oe_q;
  endproperty
  a_therm_off: assert property (p_therm_off) else $error("rails on after thermal trip");

  property p_plt_clear;
    plt_rst |=> pend_q == '0 && !irq_q;
  endproperty
  a_plt_clear: assert property (p_plt_clear) else $error("reset request ignored");

  property p_core_pg;
    $rose(core_pg_q) |-> $past(state_q) == ST_S_RAMP && $past(ramp_q) == '0 && rail_s_q;
  endproperty
  a_core_pg: assert property (p_core_pg) else $error("core good before soft start");

  property p_mem_pg;
    !o_memory_power_good_oe |-> rail_u_q && !o_memory_power_good;
  endproperty
  a_mem_pg: assert property (p_mem_pg) else $error("memory good without U rails");

  property p_irq;
    |(pend_q & ~i_irq_mask) && !plt_rst |=> irq_q;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked event not reported");

  property p_set_wins;
    event_d[IRQ_PRESS] && !plt_rst |=> pend_q[IRQ_PRESS];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");

  property p_alert;
    i_voltage_control_alert_req |=> o_voltage_control_alert_n_oe && !o_voltage_control_alert_n;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not driven low");

  property p_sw_off;
    state_q == ST_OFF |-> &o_external_switch_enable_oe;
  endproperty
  a_sw_off: assert property (p_sw_off) else $error("switch released while off");

  property p_pin8;
    i_gpio_alt_sel[ALT_SLEEP] |=> !o_gpio_oe[PIN_SLEEP];
  endproperty
  a_pin8: assert property (p_pin8) else $error("sleep pin driven");

  property p_pin9;
    i_gpio_alt_sel[ALT_MEMSEL] |=> o_gpio_out[PIN_MEMSEL] == otp_memsel_q;
  endproperty
  a_pin9: assert property (p_pin9) else $error("voltage select wrong");

  property p_panel;
    i_gpio_alt_sel[ALT_PANEL] |=> o_gpio_out[PIN_PANEL] == o_core_power_good;
  endproperty
  a_panel: assert property (p_panel) else $error("panel enable wrong");

  property p_ramp_len;
    state_q == ST_U_RAMP && ramp_q == '0 && deep_on && !plt_rst && !therm
      |=> state_q == ST_U_ON;
  endproperty
  a_ramp_len: assert property (p_ramp_len) else $error("step did not end");

  c_full_on: cover property ($rose(core_pg_q));
  c_therm: cover property (therm && rail_s_q);
  c_irq: cover property ($rose(irq_q));
  c_back_to_u: cover property (state_q == ST_S_ON ##1 state_q == ST_U_ON);
endmodule

// [design/pwr_seq_pkg.sv]
package pwr_seq_pkg;
  // Clock rate and button timing.
  localparam int unsigned CLK_KHZ     = 250_000;
  localparam int unsigned BTN_MIN_MS  = 36;
  localparam int unsigned BTN_TYP_MS  = 30;
  localparam int unsigned BTN_MIN_CYC = BTN_MIN_MS * CLK_KHZ;
  localparam int unsigned BTN_TYP_CYC = BTN_TYP_MS * CLK_KHZ;
  localparam int          DBN_CNT_W   = 24;

  // External load switches and their rail groups.
  localparam int NUM_SW = 12;
  localparam int GRP_W  = 2;
  typedef enum logic [1:0] {
    GRP_A    = 2'h0,
    GRP_U    = 2'h1,
    GRP_S    = 2'h2,
    GRP_NONE = 2'h3
  } rail_grp_t;

  // Soft-start step length comes from the factory settings.
  localparam int RAMP_W = 16;

  typedef enum logic [2:0] {
    ST_OFF    = 3'h0,
    ST_A_RAMP = 3'h1,
    ST_A_ON   = 3'h2,
    ST_U_RAMP = 3'h3,
    ST_U_ON   = 3'h4,
    ST_S_RAMP = 3'h5,
    ST_S_ON   = 3'h6
  } pwr_state_t;

  // Synchronised pin inputs, by bit position.
  localparam int                SYNC_W    = 8;
  localparam int                SY_DEEP   = 0;
  localparam int                SY_STBY   = 1;
  localparam int                SY_THERM  = 2;
  localparam int                SY_PLT    = 3;
  localparam int                SY_ACK    = 4;
  localparam int                SY_CHIPEN = 5;
  localparam int                SY_PIN8   = 6;
  localparam int                SY_BTN    = 7;
  localparam logic [SYNC_W-1:0] SYNC_RST  = 8'h8f;

  // Interrupt sources.
  localparam int IRQ_W     = 4;
  localparam int IRQ_THERM = 0;
  localparam int IRQ_PRESS = 1;
  localparam int IRQ_ACK   = 2;
  localparam int IRQ_PGOOD = 3;

  // General-purpose pins and their alternate functions.
  localparam int GPIO_W     = 15;
  localparam int PIN_SLEEP  = 8;
  localparam int PIN_MEMSEL = 9;
  localparam int PIN_PANEL  = 13;
  localparam int PIN_BLIGHT = 14;
  localparam int ALT_W      = 4;
  localparam int ALT_SLEEP  = 0;
  localparam int ALT_MEMSEL = 1;
  localparam int ALT_PANEL  = 2;
  localparam int ALT_BLIGHT = 3;
endpackage

// [design/button_if.sv]
`timescale 1ns/1ps
interface button_if;
  logic raw_n;
  logic pressed;
  logic level_n;
  modport dbn (input raw_n, output pressed, output level_n);
  modport ctl (output raw_n, input pressed, input level_n);
endinterface

// [design/button_debouncer.sv]
`timescale 1ns/1ps
module button_debouncer #(
  parameter int unsigned MIN_CYC = pwr_seq_pkg::BTN_MIN_CYC,
  parameter int unsigned TYP_CYC = pwr_seq_pkg::BTN_TYP_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  button_if.dbn     btn
);
  import pwr_seq_pkg::*;

  localparam logic [DBN_CNT_W-1:0] MIN_C = DBN_CNT_W'(MIN_CYC);
  localparam logic [DBN_CNT_W-1:0] TYP_C = DBN_CNT_W'(TYP_CYC);

  logic [DBN_CNT_W-1:0] held_q;
  logic                 level_n_q;
  logic                 pressed_q;

  // Saturating at the long threshold keeps the press pulse to one per press.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      held_q <= '0;
    end else if (btn.raw_n) begin
      held_q <= '0;
    end else if (held_q != MIN_C) begin
      held_q <= held_q + DBN_CNT_W'(1);
    end
  end

  // Release is passed on at once; only the press is filtered.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      level_n_q <= 1'b1;
    end else if (btn.raw_n) begin
      level_n_q <= 1'b1;
    end else if (held_q == TYP_C - DBN_CNT_W'(1)) begin
      level_n_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pressed_q <= 1'b0;
    end else begin
      pressed_q <= !btn.raw_n && (held_q == MIN_C - DBN_CNT_W'(1));
    end
  end

  assign btn.level_n = level_n_q;
  assign btn.pressed = pressed_q;

  property p_restart;
    @(posedge i_clk) disable iff (i_rst) btn.raw_n |=> held_q == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("debounce count did not restart");

  property p_level_after_typ;
    @(posedge i_clk) disable iff (i_rst) $fell(level_n_q) |-> $past(held_q) == TYP_C - 1;
  endproperty
  a_level_after_typ: assert property (p_level_after_typ) else $error("early debounced level");

  property p_press_single;
    @(posedge i_clk) disable iff (i_rst) pressed_q |-> held_q == MIN_C ##1 !pressed_q;
  endproperty
  a_press_single: assert property (p_press_single) else $error("bad long press pulse");

  c_press: cover property (@(posedge i_clk) disable iff (i_rst) pressed_q);
endmodule

// [sim/host_model.sv]
`timescale 1ns/1ps
module host_model (
  input  wire logic i_clk,
  output logic      o_deep_sleep_state_n,
  output logic      o_standby_state_n,
  output logic      o_platform_reset_n,
  output logic      o_suspend_powerdown_ack
);
  initial begin
    o_deep_sleep_state_n = 1'h0;
    o_standby_state_n = 1'h0;
    o_platform_reset_n = 1'h1;
    o_suspend_powerdown_ack = 1'h0;
  end

  // The host only moves its pins just after an edge, so the device never sees a
  // change and its sample in the same time step.
  task automatic drive(input logic deep_n, input logic stby_n, input logic plt_n,
                       input logic ack);
    @(posedge i_clk);
    #1;
    o_deep_sleep_state_n = deep_n;
    o_standby_state_n = stby_n;
    o_platform_reset_n = plt_n;
    o_suspend_powerdown_ack = ack;
  endtask
endmodule

// [sim/power_sequencing_control_test.sv]
`timescale 1ns/1ps
module power_sequencing_control_test;
  import pwr_seq_pkg::*;
  localparam int MIN = 40;
  localparam int TYP = 30;
  logic                    i_clk   = 1'h0;
  logic                    i_rst   = 1'h1;
  logic                    btn_n   = 1'h1;
  logic                    chip_en = 1'h0;
  logic                    therm_n = 1'h1;
  logic                    alert   = 1'h0;
  logic [IRQ_W-1:0]        mask    = 4'h0;
  logic [IRQ_W-1:0]        clr     = 4'h0;
  logic [ALT_W-1:0]        alt     = 4'h0;
  logic [GPIO_W-1:0]       gin     = 15'h0;
  logic [NUM_SW*GRP_W-1:0] grp;
  logic [RAMP_W-1:0]       ramp;
  logic                    memsel;
  logic [GPIO_W-1:0]       sw_out;
  logic [GPIO_W-1:0]       sw_oe;
  logic                    deep_n, stby_n, plt_n, ack, btn_out_n, ra, ru, rs, core;
  logic                    mem, mem_oe, irq, al, al_oe;
  logic [IRQ_W-1:0]        pend;
  logic [NUM_SW-1:0]       sw, sw_en_oe;
  logic [GPIO_W-1:0]       gout, goe;
  integer                  seed = 32'h9df1;
  int                      fails = 0, tests_run = 0, cyc = 0;
  int                      m_a = 0, m_u = 0, m_s = 0, m_core = 0, m_mem = 0, m_pend = 0;

  always #2 i_clk = ~i_clk;

  host_model i_host (.i_clk(i_clk), .o_deep_sleep_state_n(deep_n), .o_standby_state_n(stby_n),
    .o_platform_reset_n(plt_n), .o_suspend_powerdown_ack(ack));

  power_sequencing_control #(.BTN_MIN_CYC(MIN), .BTN_TYP_CYC(TYP)) i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_power_button_in_n(btn_n), .i_chip_power_enable_in(chip_en),
    .i_deep_sleep_state_n(deep_n), .i_standby_state_n(stby_n), .i_thermal_trip_in_n(therm_n),
    .i_platform_reset_n(plt_n), .i_suspend_powerdown_ack(ack),
    .i_voltage_control_alert_req(alert), .i_irq_mask(mask), .i_irq_clear(clr),
    .i_otp_switch_group(grp), .i_otp_ramp_cycles(ramp), .i_otp_memory_rail_select(memsel),
    .i_gpio_alt_sel(alt), .i_gpio_in(gin), .i_gpio_sw_out(sw_out), .i_gpio_sw_oe(sw_oe),
    .o_debounced_button_out_n(btn_out_n), .o_rail_a_enable(ra), .o_rail_u_enable(ru),
    .o_rail_s_enable(rs), .o_core_power_good(core), .o_memory_power_good(mem),
    .o_memory_power_good_oe(mem_oe), .o_irq(irq), .o_irq_pending(pend),
    .o_voltage_control_alert_n(al), .o_voltage_control_alert_n_oe(al_oe),
    .o_external_switch_enable(sw), .o_external_switch_enable_oe(sw_en_oe),
    .o_gpio_out(gout), .o_gpio_oe(goe));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // The whole run needs well under a thousand cycles; the ceiling leaves margin.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      summarize();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  // A released switch means its group is enabled; group 3 never switches on.
  function automatic logic [NUM_SW-1:0] exp_sw();
    logic [NUM_SW-1:0] v;
    int                g;
    for (int i = 0; i < NUM_SW; i++) begin
      g = grp[2*i +: 2];
      v[i] = !((g == 0 && m_a != 0) || (g == 1 && m_u != 0) || (g == 2 && m_s != 0));
    end
    return v;
  endfunction

  task automatic cmp_rails();
    chk("rail_a", m_a, ra);
    chk("rail_u", m_u, ru);
    chk("rail_s", m_s, rs);
    chk("core_good", m_core, core);
    chk("mem_good_oe", m_mem == 0, mem_oe);
    chk("switch_oe", exp_sw(), sw_en_oe);
    chk("od_data", 0, {al, mem, sw});
  endtask

  task automatic cmp_irq();
    chk("pending", m_pend, pend);
    chk("irq", |(m_pend & ~mask), irq);
  endtask

  task automatic clear_irq();
    clr = 4'hf;
    step(1);
    clr = 4'h0;
    step(2);
    m_pend = 0;
  endtask

  initial begin
    grp = $random(seed);
    ramp = 16'h8 + (16'($random(seed)) & 16'h7);
    memsel = $random(seed);
    sw_out = $random(seed);
    sw_oe = $random(seed);
    step(20);
    i_rst = 1'h0;
    step(3);
    cmp_rails();
    cmp_irq();
    chk("button_out", 1, btn_out_n);
    chk("alert_oe", 0, al_oe);
    $display("test reset done");
    repeat (3) begin
      btn_n = 1'h0;
      step(TYP - 4);
      btn_n = 1'h1;
      step(3);
    end
    step(10);
    cmp_rails();
    chk("button_out", 1, btn_out_n);
    $display("test bounce done");
    btn_n = 1'h0;
    step(TYP - 4);
    chk("button_out", 1, btn_out_n);
    step(8);
    chk("button_out", 0, btn_out_n);
    chk("rail_a", 0, ra);
    step(12);
    m_a = 1;
    m_pend = 2;
    chk("rail_a", 1, ra);
    btn_n = 1'h1;
    step(5);
    chk("button_out", 1, btn_out_n);
    step(ramp + 4);
    cmp_rails();
    cmp_irq();
    clear_irq();
    cmp_irq();
    $display("test press done");
    i_host.drive(1'h1, 1'h0, 1'h1, 1'h0);
    step(ramp + 1);
    m_u = 1;
    cmp_rails();
    step(5);
    m_mem = 1;
    cmp_rails();
    mask = 4'h8;
    i_host.drive(1'h1, 1'h1, 1'h1, 1'h0);
    step(ramp + 8);
    m_s = 1;
    m_core = 1;
    m_pend = 8;
    cmp_rails();
    cmp_irq();
    mask = 4'h0;
    step(2);
    cmp_irq();
    clear_irq();
    $display("test sequence done");
    alt = 4'hf;
    step(2);
    chk("pin9", {memsel, 1'h1}, {gout[PIN_MEMSEL], goe[PIN_MEMSEL]});
    chk("pin13_14", 4'hf, {gout[PIN_BLIGHT:PIN_PANEL], goe[PIN_BLIGHT:PIN_PANEL]});
    gin[PIN_SLEEP] = 1'h1;
    step(6);
    m_s = 0;
    m_core = 0;
    cmp_rails();
    gin[PIN_SLEEP] = 1'h0;
    step(ramp + 8);
    m_s = 1;
    m_core = 1;
    m_pend = 8;
    cmp_rails();
    cmp_irq();
    alt = 4'h0;
    step(2);
    chk("gpio", {sw_out, sw_oe}, {gout, goe});
    clear_irq();
    $display("test gpio done");
    mask = 4'h4;
    i_host.drive(1'h1, 1'h1, 1'h1, 1'h1);
    step(4);
    m_pend = 4;
    cmp_irq();
    i_host.drive(1'h1, 1'h1, 1'h1, 1'h0);
    alert = 1'h1;
    step(2);
    chk("alert_oe", 1, al_oe);
    alert = 1'h0;
    step(2);
    chk("alert_oe", 0, al_oe);
    $display("test ack alert done");
    i_host.drive(1'h1, 1'h1, 1'h0, 1'h0);
    step(5);
    m_u = 0;
    m_s = 0;
    m_core = 0;
    m_mem = 0;
    m_pend = 0;
    cmp_rails();
    cmp_irq();
    i_host.drive(1'h1, 1'h1, 1'h1, 1'h0);
    step(2 * ramp + 16);
    m_u = 1;
    m_s = 1;
    m_core = 1;
    m_mem = 1;
    m_pend = 8;
    cmp_rails();
    cmp_irq();
    $display("test platform reset done");
    mask = 4'h0;
    therm_n = 1'h0;
    step(5);
    {m_a, m_u, m_s, m_core, m_mem} = '0;
    m_pend = 9;
    cmp_rails();
    cmp_irq();
    clear_irq();
    therm_n = 1'h1;
    i_host.drive(1'h0, 1'h0, 1'h1, 1'h0);
    chip_en = 1'h1;
    step(ramp + 8);
    m_a = 1;
    cmp_rails();
    chip_en = 1'h0;
    $display("test thermal done");
    summarize();
  end
endmodule
